// *** inc/mad_pkg.sv ***
// Constants and types shared by the multiply-add datapath.
package mad_pkg;

    // ****************************************************************
    // Widths.
    // ****************************************************************
    localparam int LANES = 4;
    localparam int OPW   = 18;
    localparam int PRW   = 36;
    localparam int SUMW  = 38;

    // ****************************************************************
    // Register offsets and configuration fields.
    // ****************************************************************
    localparam logic [3:0]  REG_CFG      = 4'h0;
    localparam logic [3:0]  REG_STATUS   = 4'h4;
    localparam logic [3:0]  REG_MASK     = 4'h8;
    localparam logic [3:0]  REG_STATE    = 4'hC;
    localparam int          CFG_FOUR     = 0;
    localparam int          CFG_NARROW   = 1;
    localparam int          CFG_SHIFT    = 2;
    localparam int          CFG_CTRL_TWO = 3;
    localparam int          CFG_SIGN_REG = 4;
    localparam int          CFG_SAT_REG  = 5;
    localparam logic [5:0]  CFG_RESET    = 6'h00;
    localparam logic [3:0]  STATUS_RESET = 4'h0;
    localparam logic [3:0]  MASK_RESET   = 4'h0;

    // ****************************************************************
    // Arithmetic constants.
    // ****************************************************************
    localparam logic [17:0] Q_MIN      = 18'h20000;
    localparam logic [35:0] PROD_MAX   = 36'h7FFFFFFFF;
    localparam logic [37:0] ROUND_HALF = 38'h0000008000;
    localparam logic [37:0] ROUND_MASK = 38'h3FFFFF0000;

    // ****************************************************************
    // Adder arrangement.
    // ****************************************************************
    typedef enum logic [1:0] {
        MAD_TWO_WIDE    = 2'b00,
        MAD_TWO_NARROW  = 2'b01,
        MAD_FOUR_NARROW = 2'b11,
        MAD_FOUR_WIDE   = 2'b10
    } mad_mode_type;

endpackage

// *** inc/mad_prod_if.sv ***
// Product and saturation flag handed from one multiplier lane to the adder.
`timescale 1ns/1ns
`default_nettype none
interface mad_prod_if;
    logic [35:0] product;
    logic        saturated;
    modport src (output product, output saturated);
    modport dst (input product, input saturated);
endinterface
`default_nettype wire

// *** verif/mad_datapath_tb_top.sv ***
// Self-checking bench for the multiply-add datapath.
`timescale 1ns/1ns
`default_nettype none
module mad_datapath_tb_top;
    logic        core_clk, rstn, clr, wr_s, rd_s, irq;
    logic [71:0] op_a, op_b, fab_a, fab_b, sh, ra, rb;
    logic [17:0] sh_in, sh_out, x_re, x_im, y_re, y_im;
    logic [6:0]  ctl, c_last, rc;
    logic [3:0]  addr, exp_st, flg;
    logic [31:0] wdata, rdata, seed;
    logic [37:0] res1, res2;
    logic [5:0]  cfg;
    logic [79:0] q [$];
    int          n_errors, compares;
    logic [5:0]  modes [6] = '{6'h38, 6'h39, 6'h3A, 6'h3B, 6'h3D, 6'h00};

    mad_datapath dut (.core_clk(core_clk), .rstn(rstn), .data_clear(clr), .operand_a(op_a),
        .operand_b(op_b), .shift_in_a(sh_in), .sign_a(ctl[6]), .sign_b(ctl[5]),
        .saturate_enable(ctl[4]), .add_or_subtract_select_first(ctl[3]),
        .add_or_subtract_select_second(ctl[2]), .round_first(ctl[1]),
        .round_second(ctl[0]), .reg_addr(addr), .reg_wr_data(wdata), .reg_wr(wr_s),
        .reg_rd(rd_s), .reg_rd_data(rdata), .result_first(res1), .result_second(res2),
        .shift_out_a(sh_out), .product_zero_saturated_flag(flg[0]),
        .product_one_saturated_flag(flg[1]), .product_two_saturated_flag(flg[2]),
        .product_three_saturated_flag(flg[3]), .irq(irq));
    mad_fabric_model fab (.x_re(x_re), .x_im(x_im), .y_re(y_re), .y_im(y_im),
        .op_a(fab_a), .op_b(fab_b));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [79:0] model(input logic [71:0] a, input logic [71:0] b,
                                          input logic [6:0] c);
        longint      p [4];
        longint      r [2];
        logic [3:0]  f;
        logic [18:0] n [2][2];
        logic [18:0] q0, q1;
        for (int i = 0; i < 4; i++)
        begin
            p[i] = (c[6] ? longint'($signed(a[18*i+:18])) : longint'(a[18*i+:18])) *
                   (c[5] ? longint'($signed(b[18*i+:18])) : longint'(b[18*i+:18]));
            f[i] = !cfg[1] && c[6] && c[5] && c[4] && a[18*i+:18] == mad_pkg::Q_MIN &&
                   b[18*i+:18] == mad_pkg::Q_MIN;
            if (f[i])
                p[i] = longint'(mad_pkg::PROD_MAX);
        end
        for (int j = 0; j < 2; j++)
        begin
            r[j] = c[3-j] ? p[2*j] + p[2*j+1] : p[2*j] - p[2*j+1];
            for (int k = 0; k < 2; k++)
            begin
                q0 = a[36*j+9*k+:9] * b[36*j+9*k+:9];
                q1 = a[36*j+18+9*k+:9] * b[36*j+18+9*k+:9];
                n[j][k] = c[3-j] ? q0 + q1 : q0 - q1;
            end
        end
        for (int k = 0; k < 2; k++)
            if (cfg[0])
            begin
                n[0][k] = n[0][k] + n[1][k];
                n[1][k] = 19'h0;
            end
        if (cfg[0])
            r = '{r[0] + r[1], 0};
        for (int j = 0; j < 2; j++)
            if (c[1-j] && c[6] && c[5])
                r[j] = (r[j] + 32768) & ~longint'(65535);
        for (int j = 0; j < 2; j++)
            if (cfg[1])
                r[j] = longint'({n[j][1], n[j][0]});
        return {f, r[1][37:0], r[0][37:0]};
    endfunction

    task automatic chk(input string nm, input logic [37:0] e, input logic [37:0] g);
        compares++;
        if (g !== e)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge core_clk);
        wr_s  <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge core_clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge core_clk);
        rd_s <= 1'b0;
        #1;
        chk("reg_rd_data", 38'(e), 38'(rdata));
    endtask

    task automatic step(input logic [71:0] a, input logic [71:0] b, input logic [6:0] c);
        logic [79:0] e;
        @(posedge core_clk);
        op_a  <= a;
        op_b  <= b;
        sh_in <= a[17:0];
        ctl   <= cfg[3] ? c : c_last;
        c_last = c;
        q.push_back(model(cfg[2] ? {sh[53:0], a[17:0]} : a, b, c));
        @(negedge core_clk);
        if (cfg[2])
            chk("shift_out_a", 38'(sh[71:54]), 38'(sh_out));
        sh = {sh[53:0], a[17:0]};
        if (q.size() == 4)
        begin
            e = q.pop_front();
            exp_st = exp_st | e[79:76];
            chk("result_first", e[37:0], res1);
            chk("result_second", e[75:38], res2);
            chk("flags", 38'(e[79:76]), 38'(flg));
        end
    endtask

    task automatic finish_test();
        $display("TB: %0d compares, %0d errors", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    initial
    begin
        {rstn, clr, wr_s, rd_s, addr, wdata, op_a, op_b, sh_in, ctl} = '0;
        {c_last, cfg, sh, exp_st, n_errors, compares} = '0;
        seed = 32'hB72D;
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge core_clk);
        reg_rd(mad_pkg::REG_CFG, 32'(mad_pkg::CFG_RESET));
        reg_rd(mad_pkg::REG_STATUS, 32'(mad_pkg::STATUS_RESET));
        reg_rd(mad_pkg::REG_MASK, 32'(mad_pkg::MASK_RESET));
        foreach (modes[m])
        begin
            reg_wr(mad_pkg::REG_CFG, 32'(modes[m]));
            cfg = modes[m];
            reg_rd(mad_pkg::REG_CFG, 32'(modes[m]));
            repeat (3) step('0, '0, 7'h00);
            q.delete();
            for (int i = 0; i < 40; i++)
            begin
                ra = 72'({xs(), xs(), xs()});
                rb = 72'({xs(), xs(), xs()});
                rc = 7'(xs());
                rc[6:5] = {2{rc[6] & !cfg[1]}};
                if (cfg[0] && !cfg[1])
                    rc[1:0] = 2'b00;
                if (!cfg[1] && (i == 5 || (rc[6] && xs() % 8 == 0)))
                begin
                    ra[17:0] = mad_pkg::Q_MIN;
                    rb[17:0] = mad_pkg::Q_MIN;
                    rc[6:4] = 3'b111;
                end
                step(ra, rb, rc);
            end
            if (m == 0)
            begin
                {x_re, x_im, y_re, y_im} = 72'({xs(), xs(), xs()});
                #1;
                step(fab_a, fab_b, 7'h64);
                repeat (4) step({4{18'h00101}}, {4{18'h00203}}, 7'h08);
                @(posedge core_clk);
                clr <= 1'b1;
                #5;
                chk("cleared", 38'h0, res1 | res2);
                @(posedge core_clk);
                clr <= 1'b0;
                q.delete();
            end
            repeat (4) step('0, '0, 7'h00);
            $display("TB: mode %h done", modes[m]);
        end
        reg_rd(mad_pkg::REG_STATUS, 32'(exp_st));
        chk("irq", 38'h0, 38'(irq));
        reg_wr(mad_pkg::REG_MASK, 32'hF);
        repeat (2) @(posedge core_clk);
        #1;
        chk("irq", 38'(exp_st != 0), 38'(irq));
        reg_rd(mad_pkg::REG_STATE, {27'h0, exp_st != 0, 4'h0});
        reg_wr(mad_pkg::REG_STATUS, 32'hF);
        reg_rd(mad_pkg::REG_STATUS, 32'h0);
        chk("irq", 38'h0, 38'(irq));
        reg_wr(4'h2, 32'hFFFFFFFF);
        reg_rd(4'h2, 32'h0);
        reg_rd(mad_pkg::REG_MASK, 32'hF);
        $display("TB: register tests done");
        finish_test();
    end
endmodule
`default_nettype wire

// *** verif/mad_fabric_model.sv ***
// Fabric model that steers complex operands onto the multiplier lanes.
`timescale 1ns/1ns
`default_nettype none
module mad_fabric_model (
    input  wire logic [17:0] x_re,
    input  wire logic [17:0] x_im,
    input  wire logic [17:0] y_re,
    input  wire logic [17:0] y_im,
    output logic      [71:0] op_a,
    output logic      [71:0] op_b
);
    // Lanes 0 and 1 form the real pair, lanes 2 and 3 the imaginary pair.
    assign op_a = {x_im, x_re, x_im, x_re};
    assign op_b = {y_re, y_im, y_im, y_re};
endmodule
`default_nettype wire

// *** verilog/mad_ctrl_pipe.sv ***
// Pipeline of one or two stages for the add/subtract and round controls.
`timescale 1ns/1ns
`default_nettype none
module mad_ctrl_pipe #(
    parameter int W = 4
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         two_stage,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_q <= '0;
            s2_q <= '0;
        end
        else
        begin
            s1_q <= d;
            s2_q <= s1_q;
        end
    end

    // Depth is one or two stages as configured.
    assign q = two_stage ? s2_q : s1_q;
endmodule
`default_nettype wire

// *** verilog/mad_datapath.sv ***
// Multiply-add datapath: four lanes, pair adders, final summation, shift chain.
// Operation
// - Multiplier outputs feed the adder, summing two or four products.
// - The adder takes only multiplier products, never raw operands.
// - Two-multiplier adders: four narrow nine-bit or two wide eighteen-bit.
// - Each pair gives sum or difference, chosen at run time.
// - Add/subtract and round controls pass one or two pipeline stages.
// - Sign and saturate controls are unregistered or registered once.
// - Saturation flags appear in the same cycle as their results.
// - Wide complex multiply: real part subtracts, imaginary part adds.
// - Narrow complex: eight small multipliers feed four adders.
// - Four-multiplier sum: two pair adders, then a final summation.
// - Rounding and saturation only for signed wide fractional products.
// - Four-multiplier add/subtract controls should use the pipeline.
// - Operand A input registers can form a shift chain for FIR data.
// - One block makes a four-tap filter; longer filters cascade outside.
// - Sign controls choose signed or unsigned for each operand.
`timescale 1ns/1ns
`default_nettype none
module mad_datapath (
    input  wire logic          core_clk,
    input  wire logic          rstn,
    input  wire logic          data_clear,
    input  wire logic [71:0]   operand_a,
    input  wire logic [71:0]   operand_b,
    input  wire logic [17:0]   shift_in_a,
    input  wire logic          sign_a,
    input  wire logic          sign_b,
    input  wire logic          saturate_enable,
    input  wire logic          add_or_subtract_select_first,
    input  wire logic          add_or_subtract_select_second,
    input  wire logic          round_first,
    input  wire logic          round_second,
    input  wire logic [3:0]    reg_addr,
    input  wire logic [31:0]   reg_wr_data,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [31:0]   reg_rd_data,
    output logic      [37:0]   result_first,
    output logic      [37:0]   result_second,
    output logic      [17:0]   shift_out_a,
    output logic               product_zero_saturated_flag,
    output logic               product_one_saturated_flag,
    output logic               product_two_saturated_flag,
    output logic               product_three_saturated_flag,
    output logic               irq
);
    // ****************************************************************
    // Reset release and register file.
    // ****************************************************************
    logic        rst_m_q;
    logic        rst_sync_n;
    logic        clr_n;
    logic [5:0]  cfg_q;
    logic [3:0]  status_q;
    logic [3:0]  status_d;
    logic [3:0]  mask_q;
    logic [31:0] rd_data_q;
    logic        irq_q;
    logic [3:0]  sat_out_q;
    logic [3:0]  sat_rise;
    logic [3:0]  sat_prev_q;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_m_q    <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_m_q    <= 1'b1;
            rst_sync_n <= rst_m_q;
        end
    end

    assign clr_n = rst_sync_n & ~data_clear;

    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            cfg_q  <= mad_pkg::CFG_RESET;
            mask_q <= mad_pkg::MASK_RESET;
        end
        else if (reg_wr && reg_addr == mad_pkg::REG_CFG)
            cfg_q <= reg_wr_data[5:0];
        else if (reg_wr && reg_addr == mad_pkg::REG_MASK)
            mask_q <= reg_wr_data[3:0];
    end

    // Sticky saturation events; a new event wins over a write-one clear.
    assign sat_rise = sat_out_q & ~sat_prev_q;
    always_comb
    begin
        status_d = status_q;
        if (reg_wr && reg_addr == mad_pkg::REG_STATUS)
            status_d = status_d & ~reg_wr_data[3:0];
        status_d = status_d | sat_rise;
    end

    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            status_q   <= mad_pkg::STATUS_RESET;
            sat_prev_q <= 4'h0;
            irq_q      <= 1'b0;
        end
        else
        begin
            status_q   <= status_d;
            sat_prev_q <= sat_out_q;
            irq_q      <= |(status_d & mask_q);
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            rd_data_q <= 32'h00000000;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                mad_pkg::REG_CFG:    rd_data_q <= {26'h0000000, cfg_q};
                mad_pkg::REG_STATUS: rd_data_q <= {28'h0000000, status_q};
                mad_pkg::REG_MASK:   rd_data_q <= {28'h0000000, mask_q};
                mad_pkg::REG_STATE:  rd_data_q <= {27'h0000000, irq_q, sat_out_q};
                default:             rd_data_q <= 32'h00000000;
            endcase
        end
        else
            rd_data_q <= 32'h00000000;
    end

    // ****************************************************************
    // Input registers, shift chain and control alignment.
    // ****************************************************************
    logic [17:0]  a_q [4];
    logic [17:0]  b_q [4];
    logic         sign_a_q;
    logic         sign_b_q;
    logic         sat_en_q;
    logic         sign_a_eff;
    logic         sign_b_eff;
    logic         sat_en_eff;
    logic         narrow;
    logic         four;
    logic [3:0]   ctl;
    mad_pkg::mad_mode_type mode;

    assign narrow = cfg_q[mad_pkg::CFG_NARROW];
    assign four   = cfg_q[mad_pkg::CFG_FOUR];
    assign mode   = mad_pkg::mad_mode_type'({four, narrow});

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_in
            // Operand A registers chain into a sample shift line.
            always_ff @(posedge core_clk or negedge clr_n)
            begin
                if (!clr_n)
                begin
                    a_q[gi] <= 18'h00000;
                    b_q[gi] <= 18'h00000;
                end
                else
                begin
                    if (cfg_q[mad_pkg::CFG_SHIFT])
                        a_q[gi] <= (gi == 0) ? shift_in_a : a_q[(gi == 0) ? 0 : gi - 1];
                    else
                        a_q[gi] <= operand_a[gi*18 +: 18];
                    b_q[gi] <= operand_b[gi*18 +: 18];
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge clr_n)
    begin
        if (!clr_n)
        begin
            sign_a_q <= 1'b0;
            sign_b_q <= 1'b0;
            sat_en_q <= 1'b0;
        end
        else
        begin
            sign_a_q <= sign_a;
            sign_b_q <= sign_b;
            sat_en_q <= saturate_enable;
        end
    end

    // Sign and saturate controls bypass or take one register.
    assign sign_a_eff = cfg_q[mad_pkg::CFG_SIGN_REG] ? sign_a_q : sign_a;
    assign sign_b_eff = cfg_q[mad_pkg::CFG_SIGN_REG] ? sign_b_q : sign_b;
    assign sat_en_eff = cfg_q[mad_pkg::CFG_SAT_REG] ? sat_en_q : saturate_enable;

    // Add/subtract and round controls through the configured depth.
    mad_ctrl_pipe #(
        .W (4)
    ) u_ctrl (
        .core_clk  (core_clk),
        .rst_n     (clr_n),
        .two_stage (cfg_q[mad_pkg::CFG_CTRL_TWO]),
        .d         ({round_second, round_first,
                     add_or_subtract_select_second, add_or_subtract_select_first}),
        .q         (ctl)
    );

    // ****************************************************************
    // Multiplier lanes and product pipeline.
    // ****************************************************************
    logic [35:0] p_q [4];
    logic [3:0]  sat_q;
    logic        sig_q;
    logic        ext_q;
    logic [3:0]  lane_sat;

    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_lane
            mad_prod_if u_if ();
            mad_lane u_lane (
                .a         (a_q[gi]),
                .b         (b_q[gi]),
                .sign_a    (sign_a_eff),
                .sign_b    (sign_b_eff),
                .narrow    (narrow),
                .sat_en    (sat_en_eff),
                .prod_port (u_if)
            );
            assign lane_sat[gi] = u_if.saturated;
            // Products move on to the adder stage.
            always_ff @(posedge core_clk or negedge clr_n)
            begin
                if (!clr_n)
                begin
                    p_q[gi]   <= 36'h000000000;
                    sat_q[gi] <= 1'b0;
                end
                else
                begin
                    p_q[gi]   <= u_if.product;
                    sat_q[gi] <= u_if.saturated;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge clr_n)
    begin
        if (!clr_n)
        begin
            sig_q <= 1'b0;
            ext_q <= 1'b0;
        end
        else
        begin
            sig_q <= sign_a_eff & sign_b_eff;
            ext_q <= sign_a_eff | sign_b_eff;
        end
    end

    // ****************************************************************
    // Pair adders, final summation and rounding.
    // ****************************************************************
    function automatic logic [37:0] pair_op(input logic [35:0] x, input logic [35:0] y,
                                           input logic add, input logic nar, input logic sx);
        logic [18:0] xh;
        logic [18:0] yh;
        logic [18:0] xl;
        logic [18:0] yl;
        logic [37:0] xw;
        logic [37:0] yw;
        xh = {x[35] & sx, x[35:18]};
        yh = {y[35] & sx, y[35:18]};
        xl = {x[17] & sx, x[17:0]};
        yl = {y[17] & sx, y[17:0]};
        xw = {{2{x[35] & sx}}, x};
        yw = {{2{y[35] & sx}}, y};
        // High select adds; low takes the second from the first.
        if (nar)
            pair_op = add ? {xh + yh, xl + yl} : {xh - yh, xl - yl};
        else
            pair_op = add ? xw + yw : xw - yw;
    endfunction

    logic [37:0] pair01;
    logic [37:0] pair23;
    logic [37:0] total;
    logic [37:0] res1_d;
    logic [37:0] res2_d;
    logic        rnd_ok;

    // Adder inputs are only the registered products.
    // Real part uses a subtracting pair, imaginary an adding pair.
    assign pair01 = pair_op(p_q[0], p_q[1], ctl[0], narrow, ext_q);
    assign pair23 = pair_op(p_q[2], p_q[3], ctl[1], narrow, ext_q);
    // Final summation of the two pair results.
    assign total  = narrow ? {pair01[37:19] + pair23[37:19], pair01[18:0] + pair23[18:0]}
                           : pair01 + pair23;
    // Rounding only for signed wide products.
    assign rnd_ok = ~narrow & sig_q;

    always_comb
    begin
        unique case (mode)
            mad_pkg::MAD_TWO_WIDE, mad_pkg::MAD_TWO_NARROW:
            begin
                res1_d = pair01;
                res2_d = pair23;
            end
            mad_pkg::MAD_FOUR_WIDE, mad_pkg::MAD_FOUR_NARROW:
            begin
                res1_d = total;
                res2_d = 38'h0000000000;
            end
        endcase
        if (ctl[2] && rnd_ok)
            res1_d = (res1_d + mad_pkg::ROUND_HALF) & mad_pkg::ROUND_MASK;
        if (ctl[3] && rnd_ok && !four)
            res2_d = (res2_d + mad_pkg::ROUND_HALF) & mad_pkg::ROUND_MASK;
    end

    // Results and saturation flags leave on the same edge.
    always_ff @(posedge core_clk or negedge clr_n)
    begin
        if (!clr_n)
        begin
            result_first  <= 38'h0000000000;
            result_second <= 38'h0000000000;
            sat_out_q     <= 4'h0;
        end
        else
        begin
            result_first  <= res1_d;
            result_second <= res2_d;
            sat_out_q     <= sat_q;
        end
    end

    assign shift_out_a                  = a_q[3];
    assign product_zero_saturated_flag  = sat_out_q[0];
    assign product_one_saturated_flag   = sat_out_q[1];
    assign product_two_saturated_flag   = sat_out_q[2];
    assign product_three_saturated_flag = sat_out_q[3];
    assign reg_rd_data                  = rd_data_q;
    assign irq                          = irq_q;

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!clr_n);

    property p_flag_latency;
        $stable(clr_n) ##1 $stable(clr_n) |-> sat_out_q == $past(lane_sat, 2);
    endproperty
    a_flag_latency: assert property (p_flag_latency) else $error("flag latency");

    property p_sub_wide;
        (!four && !narrow && !ctl[0] && !ctl[2]) |=>
            result_first == $past({{2{p_q[0][35] & ext_q}}, p_q[0]}
                                  - {{2{p_q[1][35] & ext_q}}, p_q[1]});
    endproperty
    a_sub_wide: assert property (p_sub_wide) else $error("pair difference wrong");

    property p_add_wide;
        (!four && !narrow && ctl[1] && !ctl[3]) |=>
            result_second == $past({{2{p_q[2][35] & ext_q}}, p_q[2]}
                                   + {{2{p_q[3][35] & ext_q}}, p_q[3]});
    endproperty
    a_add_wide: assert property (p_add_wide) else $error("pair sum wrong");

    property p_four_sum;
        (four && !narrow && !ctl[2]) |=> result_first == $past(pair01 + pair23)
            && result_second == 38'h0000000000;
    endproperty
    a_four_sum: assert property (p_four_sum) else $error("four sum wrong");

    property p_round_only_signed;
        (ctl[2] && !narrow && sig_q && !four) |=> result_first[15:0] == 16'h0000;
    endproperty
    a_round_only_signed: assert property (p_round_only_signed) else $error("round");

    property p_shift_chain;
        cfg_q[mad_pkg::CFG_SHIFT] ##1 $stable(clr_n) |-> a_q[1] == $past(a_q[0])
            && a_q[0] == $past(shift_in_a);
    endproperty
    a_shift_chain: assert property (p_shift_chain) else $error("shift chain");

    property p_ctrl_two;
        (cfg_q[mad_pkg::CFG_CTRL_TWO] && $stable(cfg_q)) ##2 $stable(clr_n) |->
            ctl[0] == $past(add_or_subtract_select_first, 2);
    endproperty
    a_ctrl_two: assert property (p_ctrl_two) else $error("control depth two");

    property p_sign_reg;
        cfg_q[mad_pkg::CFG_SIGN_REG] ##1 $stable(clr_n) |-> sign_a_eff == $past(sign_a);
    endproperty
    a_sign_reg: assert property (p_sign_reg) else $error("sign register");

    property p_clear;
        @(posedge core_clk) disable iff (!rstn) data_clear |->
            result_first == 38'h0000000000 && sat_out_q == 4'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear ignored");

    c_four_mode:  cover property (four && !narrow);
    c_narrow_two: cover property (!four && narrow);
    c_shift_on:   cover property (cfg_q[mad_pkg::CFG_SHIFT] ##3 cfg_q[mad_pkg::CFG_SHIFT]);
    c_sat_irq:    cover property (|sat_rise ##1 irq_q);
endmodule
`default_nettype wire

// *** verilog/mad_lane.sv ***
// One multiplier lane: one wide product or two narrow products.
`timescale 1ns/1ns
`default_nettype none
module mad_lane (
    input  wire logic [17:0] a,
    input  wire logic [17:0] b,
    input  wire logic        sign_a,
    input  wire logic        sign_b,
    input  wire logic        narrow,
    input  wire logic        sat_en,
    mad_prod_if.src          prod_port
);
    logic signed [18:0] wa;
    logic signed [18:0] wb;
    logic signed [37:0] wp;
    logic signed [9:0]  ha;
    logic signed [9:0]  hb;
    logic signed [9:0]  la;
    logic signed [9:0]  lb;
    logic signed [19:0] hp;
    logic signed [19:0] lp;
    logic               at_min;

    // Each operand is signed or unsigned on its own control.
    assign wa = {sign_a & a[17], a};
    assign wb = {sign_b & b[17], b};
    assign wp = wa * wb;
    // Narrow mode splits the lane into two 9 by 9 multipliers.
    assign ha = {sign_a & a[17], a[17:9]};
    assign hb = {sign_b & b[17], b[17:9]};
    assign la = {sign_a & a[8], a[8:0]};
    assign lb = {sign_b & b[8], b[8:0]};
    assign hp = ha * hb;
    assign lp = la * lb;
    // Saturation only for signed wide fractional products.
    assign at_min = sat_en & sign_a & sign_b & ~narrow & (a == mad_pkg::Q_MIN)
                    & (b == mad_pkg::Q_MIN);

    always_comb
    begin
        if (narrow)
            prod_port.product = {hp[17:0], lp[17:0]};
        else if (at_min)
            prod_port.product = mad_pkg::PROD_MAX;
        else
            prod_port.product = wp[35:0];
        prod_port.saturated = at_min;
    end
endmodule
`default_nettype wire
